// >>> rtcad_alarm_date.v
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "rtcad_consts.vh"
// Behaviour
// R1 - Day tens in low bits 13:12
// R2 - Day units in low bits 11:8
// R3 - Weekday in low bits 2:0
// R4 - Unused bits read zero, ignore writes
// R5 - Year tens in high bits 15:12
// R6 - Year units in high bits 11:8
// R7 - Month tens in high bit 4
// R8 - Month units in high bits 3:0
// R9 - Digits passed on unchecked and uncorrected
module rtcad_alarm_date (
	input  wire        sys_clk_in,
	input  wire        rst_in,
	input  wire [1:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0]  avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output reg         avs_waitrequest_out,
	output reg  [1:0]  alarm_day_tens_out,
	output reg  [3:0]  alarm_day_units_out,
	output reg  [2:0]  alarm_weekday_out,
	output reg  [3:0]  alarm_year_tens_out,
	output reg  [3:0]  alarm_year_units_out,
	output reg         alarm_month_tens_out,
	output reg  [3:0]  alarm_month_units_out
);
	// Handshake states: a request is seen in idle and answered in the
	// following cycle, which also keeps read data on a flop
	localparam ST_IDLE   = 1'b0;
	localparam ST_ANSWER = 1'b1;

	// Reset words as parameters, so their fields can be sliced
	localparam [15:0] LOW_RST  = `RTCAD_LOW_RST;
	localparam [15:0] HIGH_RST = `RTCAD_HIGH_RST;

	// Stored words, already masked inside the register instances
	wire [15:0] low_q;
	wire [15:0] high_q;

	// Field slices handed to the output flops
	wire [1:0]  day_tens_nxt;
	wire [3:0]  day_units_nxt;
	wire [2:0]  weekday_nxt;
	wire [3:0]  year_tens_nxt;
	wire [3:0]  year_units_nxt;
	wire        month_tens_nxt;
	wire [3:0]  month_units_nxt;

	// Bus decode and handshake
	wire        req;
	wire        sel_low;
	wire        sel_high;
	wire        wr_accept;
	wire        wr_low;
	wire        wr_high;
	reg         state_r;
	reg         state_nxt;
	reg         waitrequest_nxt;
	reg         rdata_load;
	reg  [31:0] rdata_nxt;

	// Either direction counts as a request; the master never raises both
	assign req      = avs_read_in | avs_write_in;
	assign sel_low  = (avs_address_in == `RTCAD_OFS_LOW);
	assign sel_high = (avs_address_in == `RTCAD_OFS_HIGH);

	// Writes land only at the edge where the master sees waitrequest low,
	// so the word changes exactly when the master counts the write as done
	assign wr_accept = avs_write_in & (state_r == ST_ANSWER);
	assign wr_low    = wr_accept & sel_low;
	assign wr_high   = wr_accept & sel_high;
	// Unmapped addresses select neither word, so writes there are dropped
	// Byte lanes 3:2 and write data bits 31:16 have nothing behind them

	// R4 masked storage
	rtcad_field_reg #(
		.MASK (`RTCAD_LOW_MASK),
		.RST  (`RTCAD_LOW_RST)
	) u_low (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.wr_en_in   (wr_low),
		.be_in      (avs_byteenable_in[1:0]),
		.wdata_in   (avs_writedata_in[15:0]),
		.q_out      (low_q)
	);

	// R4 masked storage
	rtcad_field_reg #(
		.MASK (`RTCAD_HIGH_MASK),
		.RST  (`RTCAD_HIGH_RST)
	) u_high (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.wr_en_in   (wr_high),
		.be_in      (avs_byteenable_in[1:0]),
		.wdata_in   (avs_writedata_in[15:0]),
		.q_out      (high_q)
	);

	// R4 unused bits read zero
	// Storage is masked already, so the mux needs no masking of its own;
	// the upper half-word and unmapped addresses read zero
	always @*
	begin
		case (avs_address_in)
			`RTCAD_OFS_LOW:  rdata_nxt = {16'h0000, low_q};
			`RTCAD_OFS_HIGH: rdata_nxt = {16'h0000, high_q};
			default:         rdata_nxt = `RTCAD_UNMAPPED;
		endcase
	end

	// Handshake next state: one wait state per request, then a cycle with
	// waitrequest high, so a request still held is never answered twice
	always @*
	begin
		state_nxt       = state_r;
		waitrequest_nxt = 1'b1;
		rdata_load      = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				if (req)
				begin
					state_nxt       = ST_ANSWER;
					waitrequest_nxt = 1'b0;
					// Read data are taken now and stand while the master samples
					rdata_load      = avs_read_in;
				end
			end
			ST_ANSWER:
			begin
				// The master releases at this edge; go back to idle
				state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Handshake registers; waitrequest mirrors the state but has its own
	// flop so the port leaves a register directly; read data stand until
	// the next read is answered
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r             <= ST_IDLE;
			avs_waitrequest_out <= `RTCAD_WAIT_RST;
			avs_readdata_out    <= `RTCAD_RDATA_RST;
		end
		else
		begin
			state_r             <= state_nxt;
			avs_waitrequest_out <= waitrequest_nxt;
			if (rdata_load)
				avs_readdata_out <= rdata_nxt;
		end
	end

	// Field slices; each digit goes out exactly as stored
	// R1 day tens
	assign day_tens_nxt    = low_q[`RTCAD_DAYT_HI:`RTCAD_DAYT_LO];
	// R2 day units
	assign day_units_nxt   = low_q[`RTCAD_DAYU_HI:`RTCAD_DAYU_LO];
	// R3 weekday field
	assign weekday_nxt     = low_q[`RTCAD_ALARM_WEEKDAY_HI:`RTCAD_ALARM_WEEKDAY_LO];
	// R5 year tens
	assign year_tens_nxt   = high_q[`RTCAD_YRT_HI:`RTCAD_YRT_LO];
	// R6 year units
	assign year_units_nxt  = high_q[`RTCAD_YRU_HI:`RTCAD_YRU_LO];
	// R7 month tens
	assign month_tens_nxt  = high_q[`RTCAD_MTHT_BIT];
	// R8 month units
	assign month_units_nxt = high_q[`RTCAD_MTHU_HI:`RTCAD_MTHU_LO];

	// Low-word fields, one edge behind the stored word so every output
	// leaves a flop; a date written lane by lane reaches the comparator in
	// steps, so software should hold matching off while it rewrites
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			alarm_day_tens_out    <= LOW_RST[`RTCAD_DAYT_HI:`RTCAD_DAYT_LO];
			alarm_day_units_out   <= LOW_RST[`RTCAD_DAYU_HI:`RTCAD_DAYU_LO];
			alarm_weekday_out     <= LOW_RST[`RTCAD_ALARM_WEEKDAY_HI:`RTCAD_ALARM_WEEKDAY_LO];
		end
		else
		begin
			// R9 no range check
			alarm_day_tens_out    <= day_tens_nxt;
			alarm_day_units_out   <= day_units_nxt;
			alarm_weekday_out     <= weekday_nxt;
		end
	end

	// High-word fields, the same one-edge delay
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			alarm_year_tens_out   <= HIGH_RST[`RTCAD_YRT_HI:`RTCAD_YRT_LO];
			alarm_year_units_out  <= HIGH_RST[`RTCAD_YRU_HI:`RTCAD_YRU_LO];
			alarm_month_tens_out  <= HIGH_RST[`RTCAD_MTHT_BIT];
			alarm_month_units_out <= HIGH_RST[`RTCAD_MTHU_HI:`RTCAD_MTHU_LO];
		end
		else
		begin
			// R9 no range check
			alarm_year_tens_out   <= year_tens_nxt;
			alarm_year_units_out  <= year_units_nxt;
			alarm_month_tens_out  <= month_tens_nxt;
			alarm_month_units_out <= month_units_nxt;
		end
	end
endmodule // rtcad_alarm_date

// >>> rtcad_consts.vh
`ifndef RTCAD_CONSTS_VH
`define RTCAD_CONSTS_VH
// Register word indices on the Avalon-MM slave
`define RTCAD_OFS_LOW       2'h0
`define RTCAD_OFS_HIGH      2'h1
// Reset values of the two registers
`define RTCAD_LOW_RST       16'h0000
`define RTCAD_HIGH_RST      16'h0000
// Reset values of the bus outputs
`define RTCAD_RDATA_RST     32'h00000000
`define RTCAD_WAIT_RST      1'b1
// Writable bit masks; every other bit reads as zero
`define RTCAD_LOW_MASK      16'h3f07
`define RTCAD_HIGH_MASK     16'hff1f
// Field positions in the low register
`define RTCAD_DAYT_HI       13
`define RTCAD_DAYT_LO       12
`define RTCAD_DAYU_HI       11
`define RTCAD_DAYU_LO       8
`define RTCAD_ALARM_WEEKDAY_HI       2
`define RTCAD_ALARM_WEEKDAY_LO       0
// Field positions in the high register
`define RTCAD_YRT_HI        15
`define RTCAD_YRT_LO        12
`define RTCAD_YRU_HI        11
`define RTCAD_YRU_LO        8
`define RTCAD_MTHT_BIT      4
`define RTCAD_MTHU_HI       3
`define RTCAD_MTHU_LO       0
// Answer to an unmapped address
`define RTCAD_UNMAPPED      32'h00000000
`endif

// >>> rtcad_field_reg.v
`timescale 1ns/1ps
`include "rtcad_consts.vh"
// One masked 16-bit register; bits outside the mask are held at zero
module rtcad_field_reg #(
	parameter [15:0] MASK  = 16'hffff,
	parameter [15:0] RST   = 16'h0000
) (
	input  wire        sys_clk_in,
	input  wire        rst_in,
	input  wire        wr_en_in,
	input  wire [1:0]  be_in,
	input  wire [15:0] wdata_in,
	output reg  [15:0] q_out
);
	reg [15:0] q_nxt;

	// Byte-lane merge, then masking so unused bits never store
	always @*
	begin
		q_nxt = q_out;
		if (wr_en_in)
		begin
			if (be_in[0])
				q_nxt[7:0] = wdata_in[7:0];
			if (be_in[1])
				q_nxt[15:8] = wdata_in[15:8];
		end
		q_nxt = q_nxt & MASK;
	end

	// Storage
	always @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			q_out <= RST & MASK;
		else
			q_out <= q_nxt;
	end
endmodule // rtcad_field_reg

// >>> rtcad_alarm_date_properties.sv
`timescale 1ns/1ps
module rtcad_props (
	input wire        sys_clk_in,
	input wire        rst_in,
	input wire [1:0]  avs_address_in,
	input wire        avs_read_in,
	input wire        avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0]  avs_byteenable_in,
	input wire [31:0] avs_readdata_out,
	input wire        avs_waitrequest_out,
	input wire [1:0]  alarm_day_tens_out,
	input wire [3:0]  alarm_day_units_out,
	input wire [2:0]  alarm_weekday_out,
	input wire [3:0]  alarm_year_tens_out,
	input wire [3:0]  alarm_year_units_out,
	input wire        alarm_month_tens_out,
	input wire [3:0]  alarm_month_units_out
);
	// Accepted write lanes; fields show them two edges later
	wire        w = avs_write_in & ~avs_waitrequest_out;
	wire [1:0]  l = {2{w & (avs_address_in == 2'h0)}} & avs_byteenable_in[1:0];
	wire [1:0]  h = {2{w & (avs_address_in == 2'h1)}} & avs_byteenable_in[1:0];
	wire [15:0] v = avs_writedata_in[15:0];
	// Bits that may read as one at the addressed word
	wire [15:0] rmask = avs_address_in[1] ? 16'h0000 :
		avs_address_in[0] ? 16'hff1f : 16'h3f07;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// A request raised while the slave waits, its answer, a read answered
	sequence s_taken;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_answer;
		!avs_waitrequest_out;
	endsequence
	sequence s_read_done;
		avs_read_in && !avs_waitrequest_out;
	endsequence
	a_one_wait: assert property (s_taken |=> s_answer)
		else $error("request not answered in the next cycle");
	a_wait_again: assert property (s_answer |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	a_day_tens: assert property (l[1] |-> ##2 alarm_day_tens_out == $past(v[13:12], 2))
		else $error("day tens");
	a_day_units: assert property (l[1] |-> ##2 alarm_day_units_out == $past(v[11:8], 2))
		else $error("day units");
	a_weekday_field: assert property (l[0] |-> ##2 alarm_weekday_out == $past(v[2:0], 2))
		else $error("weekday");
	a_year_tens: assert property (h[1] |-> ##2 alarm_year_tens_out == $past(v[15:12], 2))
		else $error("year tens");
	a_year_units: assert property (h[1] |-> ##2 alarm_year_units_out == $past(v[11:8], 2))
		else $error("year units");
	a_month_tens: assert property (h[0] |-> ##2 alarm_month_tens_out == $past(v[4], 2))
		else $error("month tens");
	a_month_units: assert property (h[0] |-> ##2 alarm_month_units_out == $past(v[3:0], 2))
		else $error("month units");
	a_unused_zero: assert property (s_read_done |->
		(avs_readdata_out & ~{16'h0000, rmask}) == 32'h0) else $error("unused bits");
endmodule // rtcad_props
bind rtcad_alarm_date rtcad_props u_props (
	.sys_clk_in            (sys_clk_in),
	.rst_in                (rst_in),
	.avs_address_in        (avs_address_in),
	.avs_read_in           (avs_read_in),
	.avs_write_in          (avs_write_in),
	.avs_writedata_in      (avs_writedata_in),
	.avs_byteenable_in     (avs_byteenable_in),
	.avs_readdata_out      (avs_readdata_out),
	.avs_waitrequest_out   (avs_waitrequest_out),
	.alarm_day_tens_out    (alarm_day_tens_out),
	.alarm_day_units_out   (alarm_day_units_out),
	.alarm_weekday_out     (alarm_weekday_out),
	.alarm_year_tens_out   (alarm_year_tens_out),
	.alarm_year_units_out  (alarm_year_units_out),
	.alarm_month_tens_out  (alarm_month_tens_out),
	.alarm_month_units_out (alarm_month_units_out)
);

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	reg sys_clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0;
	reg [1:0] avs_address_in = 0, a;
	reg [3:0] avs_byteenable_in = 0;
	reg [31:0] avs_writedata_in = 0, s = 32'hf228;
	wire [31:0] avs_readdata_out;
	wire avs_waitrequest_out, alarm_month_tens_out;
	wire [1:0] alarm_day_tens_out;
	wire [2:0] alarm_weekday_out;
	wire [3:0] alarm_day_units_out, alarm_year_tens_out;
	wire [3:0] alarm_year_units_out, alarm_month_units_out;
	// All field outputs packed, in the same order as fld below
	wire [31:0] fields = {10'h000, alarm_day_tens_out, alarm_day_units_out,
		alarm_weekday_out, alarm_year_tens_out, alarm_year_units_out,
		alarm_month_tens_out, alarm_month_units_out};
	reg [15:0] m [4];
	int fails = 0, cmp_count = 0, i, c = 0;
	rtcad_alarm_date dut (
		.sys_clk_in            (sys_clk_in),
		.rst_in                (rst_in),
		.avs_address_in        (avs_address_in),
		.avs_read_in           (avs_read_in),
		.avs_write_in          (avs_write_in),
		.avs_writedata_in      (avs_writedata_in),
		.avs_byteenable_in     (avs_byteenable_in),
		.avs_readdata_out      (avs_readdata_out),
		.avs_waitrequest_out   (avs_waitrequest_out),
		.alarm_day_tens_out    (alarm_day_tens_out),
		.alarm_day_units_out   (alarm_day_units_out),
		.alarm_weekday_out     (alarm_weekday_out),
		.alarm_year_tens_out   (alarm_year_tens_out),
		.alarm_year_units_out  (alarm_year_units_out),
		.alarm_month_tens_out  (alarm_month_tens_out),
		.alarm_month_units_out (alarm_month_units_out)
	);
	// 8 ns clock; the cycle ceiling cuts a hang short
	always #4 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) if (++c == 3000) wrap_up;
	// Random source and expected word after a masked, lane-enabled write
	function [31:0] xs(input [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ x << 5;
	endfunction
	function [15:0] upd(input [15:0] o, input [1:0] r, input [3:0] b, input [15:0] d);
		upd = {{8{b[1]}}, {8{b[0]}}} & (r[1] ? 16'h0 : r[0] ? 16'hff1f : 16'h3f07);
		return o & ~upd | d & upd;
	endfunction
	// Expected field outputs from the two stored words, digits as written
	function [31:0] fld(input [15:0] lo, input [15:0] hi);
		return {10'h000, lo[13:12], lo[11:8], lo[2:0], hi[15:12], hi[11:8], hi[4], hi[3:0]};
	endfunction
	task chk(input [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) fails++;
		if (seen !== exp) $display("unexpected at %0t: %h expected %h", $time, seen, exp);
	endtask
	// Hold the request until waitrequest is sampled low, then release it
	task bus(input wr, input [15:0] exp);
		avs_read_in <= !wr;
		avs_write_in <= wr;
		@(posedge sys_clk_in);
		while (avs_waitrequest_out) @(posedge sys_clk_in);
		if (!wr) chk(avs_readdata_out, {16'h0, exp});
		avs_read_in <= 0;
		avs_write_in <= 0;
		@(posedge sys_clk_in);
	endtask
	task wrap_up;
		fails += c >= 3000;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Reset, then all-ones corners on both words, then random traffic
	initial
	begin
		m = '{default: 16'h0};
		repeat (10) @(posedge sys_clk_in);
		rst_in <= 0;
		@(posedge sys_clk_in);
		chk(fields, fld(m[0], m[1]));
		$display("reset values done");
		for (i = 0; i < 60; i++)
		begin
			s = xs(s);
			a = i < 4 ? {1'b0, i[0]} : s[9:8];
			avs_address_in <= a;
			avs_writedata_in <= i < 2 ? '1 : s;
			avs_byteenable_in <= i < 2 ? 4'hf : s[3:0];
			bus(0, m[a]);
			bus(1, 16'h0);
			m[a] = upd(m[a], a, avs_byteenable_in, avs_writedata_in[15:0]);
			// Fields follow the stored word one edge after the write lands
			@(posedge sys_clk_in);
			chk(fields, fld(m[0], m[1]));
		end
		$display("corner and random pass done");
		wrap_up;
	end
endmodule // tb
